/* pkg/frac_pkg.sv */
// frac_pkg: constants for the flash command host controller
// assumes a byte-wide parallel flash with 18 address bits, host clock 125 MHz
package frac_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  // command codes
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_RESET     = 8'hFF;
  localparam logic [7:0] CMD_PROG_A    = 8'h10;
  localparam logic [7:0] CMD_PROG_B    = 8'h50;
  localparam logic [7:0] CMD_ERASE     = 8'h30;
  localparam logic [7:0] CMD_ASEL_A    = 8'h80;
  localparam logic [7:0] CMD_ASEL_B    = 8'h90;
  localparam logic [7:0] NULL_DATA     = 8'hFF;
  // auto select addresses
  localparam logic [17:0] ID_MFR_ADDR  = 18'h00000;
  localparam logic [17:0] ID_DEV_ADDR  = 18'h00001;
  localparam int POLL_BIT = 7;
  // bus timing: pulse widths and access time in ns
  localparam int CLK_NS     = 8;
  localparam int PULSE_NS   = 50;
  localparam int ACCESS_NS  = 70;
  localparam int PULSE_CYC  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PULSE_CNT  = 4'(PULSE_CYC);
  localparam logic [3:0] ACCESS_CNT = 4'(ACCESS_CYC);
  localparam logic [3:0] CNT_ZERO   = 4'h0;
  localparam logic [3:0] CNT_ONE    = 4'h1;
  // host operations requested on the user side
  typedef enum logic [2:0] {
    FRAC_OP_READ  = 3'h0,
    FRAC_OP_RESET = 3'h1,
    FRAC_OP_PROG  = 3'h2,
    FRAC_OP_ERASE = 3'h3,
    FRAC_OP_IDENT = 3'h4,
    FRAC_OP_MASK  = 3'h5
  } frac_op_t;
endpackage : frac_pkg

/* src/frac_bus_cycle.sv */
// frac_bus_cycle: one timed read or write cycle on the flash pins
// assumes the flash data pins come back through dq_in_i from a pad
`timescale 1ns/1ps
module frac_bus_cycle (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  dq_in_i,
  output logic             done_o,
  output logic [7:0]       rdata_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [17:0]      addr_o,
  output logic [7:0]       dq_out_o,
  output logic             dq_oe_o
);
  logic       busy;
  logic [3:0] cnt;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  wire        last = busy && (cnt == frac_pkg::CNT_ZERO);
  wire  [3:0] len  = write_i ? frac_pkg::PULSE_CNT : frac_pkg::ACCESS_CNT;

  //////////////////////////////////////////////////////////////////////////////
  // pad data synchroniser, two flops before any use
  always_ff @(posedge ref_clk_i) begin
    if (clk_en_i) begin
      dq_s1 <= dq_in_i;
      dq_s2 <= dq_s1;
    end
  end

  // strobe sequencing; extra sync latency is covered by the access count
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      busy <= 1'b0; cnt <= frac_pkg::CNT_ZERO; done_o <= 1'b0; rdata_o <= 8'h00;
      ce_n_o <= 1'b1; oe_n_o <= 1'b1; we_n_o <= 1'b1;
      addr_o <= 18'h00000; dq_out_o <= 8'h00; dq_oe_o <= 1'b0;
    end else if (clk_en_i) begin
      done_o <= 1'b0;
      if (start_i && !busy) begin
        busy <= 1'b1; cnt <= len + frac_pkg::CNT_ONE;
        ce_n_o <= 1'b0; oe_n_o <= write_i; we_n_o <= !write_i;
        addr_o <= addr_i; dq_out_o <= wdata_i; dq_oe_o <= write_i;
      end else if (last) begin
        // raise strobes only; the flash latches data on the rising write strobe,
        // so select and data must still stand at that edge
        busy <= 1'b0; done_o <= 1'b1; rdata_o <= dq_s2;
        oe_n_o <= 1'b1; we_n_o <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - frac_pkg::CNT_ONE;
      end else begin
        // idle: select and data released one cycle after the strobe
        ce_n_o <= 1'b1; dq_oe_o <= 1'b0;
      end
    end
  end
endmodule : frac_bus_cycle

/* src/frac_host.sv */
// frac_host: host controller issuing command sequences to a parallel flash
// assumes one flash device on the pins; masking is a read command to it
`timescale 1ns/1ps
module frac_host (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        clk_en_i,
  input  wire logic        req_i,
  input  wire logic [2:0]  op_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [7:0]  dq_in_i,
  output logic             busy_o,
  output logic             done_o,
  output logic [7:0]       rdata_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic [17:0]      addr_o,
  output logic [7:0]       dq_out_o,
  output logic             dq_oe_o
);
  typedef enum logic [4:0] {
    FRAC_IDLE  = 5'b00001,
    FRAC_WR1   = 5'b00010,
    FRAC_WR2   = 5'b00100,
    FRAC_POLL  = 5'b01000,
    FRAC_RD    = 5'b10000
  } frac_state_t;

  frac_state_t       state;
  frac_state_t       next_state;
  frac_pkg::frac_op_t op;
  logic [17:0]       addr;
  logic [7:0]        wdata;
  logic              cyc_start;
  logic              cyc_done;
  logic [7:0]        cyc_rdata;
  logic              cyc_write;
  logic [17:0]       cyc_addr;
  logic [7:0]        cyc_wdata;

  //////////////////////////////////////////////////////////////////////////////
  // first and second written byte of each operation
  // reset op ends ident; erase is one shareable command
  wire [7:0] first_byte =
      (op == frac_pkg::FRAC_OP_RESET) ? frac_pkg::CMD_RESET :
      (op == frac_pkg::FRAC_OP_PROG)  ? frac_pkg::CMD_PROG_A :
      (op == frac_pkg::FRAC_OP_ERASE) ? frac_pkg::CMD_ERASE :
      (op == frac_pkg::FRAC_OP_IDENT) ? frac_pkg::CMD_ASEL_B :
                                        frac_pkg::CMD_READ;
  wire [7:0] second_byte =
      (op == frac_pkg::FRAC_OP_PROG)  ? wdata :
      (op == frac_pkg::FRAC_OP_ERASE) ? frac_pkg::CMD_ERASE :
                                        frac_pkg::CMD_RESET;
  // reset is always two writes, safe in setup state too
  wire two_writes = (op == frac_pkg::FRAC_OP_RESET) || (op == frac_pkg::FRAC_OP_PROG) ||
                    (op == frac_pkg::FRAC_OP_ERASE);
  // all-ones data is a null program, skip the poll
  wire null_prog  = (op == frac_pkg::FRAC_OP_PROG) && (wdata == frac_pkg::NULL_DATA);
  wire needs_poll = ((op == frac_pkg::FRAC_OP_PROG) && !null_prog) ||
                    (op == frac_pkg::FRAC_OP_ERASE);
  // plain reads issue no command; ident reads the given address
  wire read_only  = (op == frac_pkg::FRAC_OP_READ);
  wire ends_read  = (op == frac_pkg::FRAC_OP_IDENT) || read_only;
  // poll: program expects true bit, erase expects one
  wire [7:0] expect_byte = (op == frac_pkg::FRAC_OP_ERASE) ? frac_pkg::NULL_DATA : wdata;
  wire poll_ok = (cyc_rdata[frac_pkg::POLL_BIT] == expect_byte[frac_pkg::POLL_BIT]);

  assign cyc_write = (state == FRAC_WR1) || (state == FRAC_WR2);
  assign cyc_wdata = (state == FRAC_WR2) ? second_byte : first_byte;
  // ident reads use caller address (0000h or 0001h)
  assign cyc_addr  = addr;
  assign cyc_start = (state != FRAC_IDLE) && !cyc_done;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      FRAC_IDLE: begin
        if (req_i) begin
          next_state = (op_i == frac_pkg::FRAC_OP_READ) ? FRAC_RD : FRAC_WR1;
        end
      end
      FRAC_WR1: begin
        if (cyc_done) begin
          next_state = two_writes ? FRAC_WR2 : (ends_read ? FRAC_RD : FRAC_IDLE);
        end
      end
      FRAC_WR2: begin
        if (cyc_done) begin
          next_state = needs_poll ? FRAC_POLL : FRAC_IDLE;
        end
      end
      FRAC_POLL: begin
        // poll until the bit matches; no timeout by design
        if (cyc_done && poll_ok) begin
          next_state = FRAC_IDLE;
        end
      end
      FRAC_RD: begin
        if (cyc_done) begin
          next_state = FRAC_IDLE;
        end
      end
      default: next_state = FRAC_IDLE;
    endcase
  end

  // state and request capture
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= FRAC_IDLE; op <= frac_pkg::FRAC_OP_READ; addr <= 18'h00000;
      wdata <= 8'h00; busy_o <= 1'b0; done_o <= 1'b0; rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      state  <= next_state;
      busy_o <= (next_state != FRAC_IDLE);
      done_o <= (state != FRAC_IDLE) && (next_state == FRAC_IDLE);
      if ((state == FRAC_IDLE) && req_i) begin
        op <= frac_pkg::frac_op_t'(op_i); addr <= addr_i; wdata <= wdata_i;
      end
      if (cyc_done && !cyc_write) begin
        rdata_o <= cyc_rdata;
      end
    end
  end

  frac_bus_cycle u_cycle (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .clk_en_i  (clk_en_i),
    .start_i   (cyc_start),
    .write_i   (cyc_write),
    .addr_i    (cyc_addr),
    .wdata_i   (cyc_wdata),
    .dq_in_i   (dq_in_i),
    .done_o    (cyc_done),
    .rdata_o   (cyc_rdata),
    .ce_n_o    (ce_n_o),
    .oe_n_o    (oe_n_o),
    .we_n_o    (we_n_o),
    .addr_o    (addr_o),
    .dq_out_o  (dq_out_o),
    .dq_oe_o   (dq_oe_o)
  );
endmodule : frac_host

/* tb/frac_flash_model.sv */
// frac_flash_model: behavioural byte-wide flash answering the host's strobes
// assumes strobes from frac_host; 16 cells alias the whole address space
`timescale 1ns/1ps
module frac_flash_model #(
  parameter logic [7:0] MFR_ID  = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_ID  = 8'hC3, // arbitrary value
  parameter int         BUSY_NS = 400
) (
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  din_i,
  output logic [7:0]       dout_o
);
  logic [7:0] mem [16];
  logic [7:0] rd, hold, pval;
  logic [1:0] mode; // 0 array, 1 program staged, 2 ident, 3 erase staged
  logic       busy, erasing;
  wire        drv = !ce_n_i && !oe_n_i;
  ////////////////////////////////////////////////////////////////////////
  // powers up reading array
  initial begin
    mode = 2'h0; busy = 1'b0; erasing = 1'b0; hold = 8'h00; pval = 8'h00;
    for (int i = 0; i < 16; i++) mem[i] = 8'h3C ^ 8'(i * 7);
  end
  // read path; released bus shows inverse, not stale data
  always @* begin
    if (busy) rd = erasing ? 8'h00 : {~pval[7], mem[addr_i[3:0]][6:0]};
    else if (mode == 2'h2) rd = (addr_i == 0) ? MFR_ID : (addr_i == 1) ? DEV_ID : 8'h00;
    else rd = mem[addr_i[3:0]];
    if (drv) hold = rd;
  end
  assign dout_o = drv ? rd : ~hold;
  always @(posedge we_n_i) if (!ce_n_i && !busy) begin
    if (mode == 2'h1 && din_i == 8'hFF) begin // all-ones data is a null write
      mode = 2'h0;
    end else if (mode == 2'h1) begin // cells only clear
      mem[addr_i[3:0]] = mem[addr_i[3:0]] & din_i;
      pval = din_i; erasing = 1'b0; busy = 1'b1; mode = 2'h0;
      busy <= #BUSY_NS 1'b0;
    end else if (mode == 2'h3 && din_i == 8'h30) begin
      for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
      erasing = 1'b1; busy = 1'b1; mode = 2'h0;
      busy <= #(2 * BUSY_NS) 1'b0;
    end else case (din_i) // reset, read and unknown codes leave cells alone
      8'h10, 8'h50: mode = 2'h1;
      8'h30:        mode = 2'h3;
      8'h80, 8'h90: mode = 2'h2;
      default:      mode = 2'h0;
    endcase
  end
endmodule : frac_flash_model

/* tb/frac_host_chk.sv */
// frac_host_chk: port-level checks on the flash host controller
// assumes single clock ref_clk_i and sync reset_i
`timescale 1ns/1ps
module frac_host_chk (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        clk_en_i,
  input wire logic        req_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        ce_n_o,
  input wire logic        oe_n_o,
  input wire logic        we_n_o,
  input wire logic [17:0] addr_o,
  input wire logic [7:0]  dq_out_o,
  input wire logic        dq_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_done_one_cycle: assert property (done_o && clk_en_i |=> !done_o)
    else $error("done_o longer than one cycle");
  a_busy_from_req: assert property ($rose(busy_o) |-> $past(req_i))
    else $error("busy_o rose without request");
  a_idle_no_strobe: assert property (!busy_o |-> we_n_o && oe_n_o)
    else $error("strobe active while idle");
  a_no_contention: assert property (!oe_n_o |-> !dq_oe_o && we_n_o)
    else $error("host drives data during flash read");
  a_write_drives: assert property (!we_n_o |-> dq_oe_o && !ce_n_o)
    else $error("write strobe without data or select");
  a_write_width: assert property ($fell(we_n_o) |=> !we_n_o [*5])
    else $error("write pulse too short");
  a_write_stable: assert property (!we_n_o && $past(!we_n_o) |-> $stable(addr_o)
    && $stable(dq_out_o))
    else $error("address or data moved in write pulse");
  a_start_bound: assert property ($rose(busy_o) |-> ##[1:4] (!we_n_o || !oe_n_o))
    else $error("cycle did not start after request");
  a_reset_quiet: assert property (disable iff (1'b0) reset_i |=> ce_n_o && !dq_oe_o)
    else $error("pins active after reset");
  // a frozen edge must leave busy, done, select, both strobes and data drive where they were
  a_freeze_hold: assert property (!clk_en_i |=> $stable(busy_o) && $stable(done_o)
    && $stable(ce_n_o) && $stable(we_n_o) && $stable(oe_n_o) && $stable(dq_oe_o))
    else $error("state moved while clock enable low");
  c_write: cover property ($fell(we_n_o));
  c_read: cover property ($fell(oe_n_o));
  c_done: cover property (done_o);
endmodule : frac_host_chk
bind frac_host frac_host_chk u_frac_host_chk (.*);

/* tb/tb.sv */
// tb: self-checking bench for frac_host against a behavioural flash
// assumes expected rdata per op is queued and popped on done_o
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] MFR = 8'h5A; // arbitrary value
  localparam logic [7:0] DEV = 8'hC3; // arbitrary value
  logic clk = 0, rst = 1, req = 0;
  logic ce = 1, gate = 0;
  logic [2:0] op = 0;
  logic [17:0] a = 0, ad;
  logic [7:0] wd = 0, d, last, mem [16], q [$], e;
  wire busy, done, ce_n, oe_n, we_n, dq_oe;
  wire [7:0] rdata, dq_o, fq;
  wire [17:0] ao;
  wire [7:0] dq = dq_oe ? dq_o : fq; // resolved data pins
  int bad_count = 0, samples_checked = 0, r;
  always #4 clk = ~clk;
  // enable drops every other edge while gated, stretching every bus phase
  always @(posedge clk) ce <= gate ? !ce : 1'b1;
  frac_host u_frac_host (.ref_clk_i(clk), .reset_i(rst), .clk_en_i(ce), .req_i(req),
    .op_i(op), .addr_i(a), .wdata_i(wd), .dq_in_i(dq), .busy_o(busy), .done_o(done),
    .rdata_o(rdata), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(ao),
    .dq_out_o(dq_o), .dq_oe_o(dq_oe));
  frac_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV)) u_frac_flash_model (.ce_n_i(ce_n),
    .oe_n_i(oe_n), .we_n_i(we_n), .addr_i(ao), .din_i(dq), .dout_o(fq));
  ////////////////////////////////////////////////////////////////////////
  task conclude;
    if (bad_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // one op: note expected rdata, hold req until taken, wait for idle
  task run(input logic [2:0] o, input logic [17:0] x, input logic [7:0] y,
           input logic [7:0] ex);
    q.push_back(ex);
    last = ex;
    @(posedge clk); req <= 1'b1; op <= o; a <= x; wd <= y;
    do @(posedge clk); while (busy !== 1'b1);
    req <= 1'b0;
    while (busy !== 1'b0) @(posedge clk);
  endtask : run
  // compare oldest note whenever an op ends
  always @(posedge clk) if (done === 1'b1 && ce === 1'b1) begin
    e = q.pop_front();
    samples_checked++;
    if (rdata !== e) begin
      bad_count++;
      $display("[FAIL] rdata_o exp %h got %h", e, rdata);
    end
  end
  // hang guard, far beyond the thousand or so cycles the ops take
  initial begin
    #200000;
    bad_count++;
    conclude;
  end
  initial begin
    r = $urandom(32'h051DF195);
    for (int i = 0; i < 16; i++) mem[i] = 8'h3C ^ 8'(i * 7);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    run(3'h0, 18'h3, 8'h0, mem[3]);
    run(3'h4, 18'h0, 8'h0, MFR);
    run(3'h4, 18'h1, 8'h0, DEV);
    run(3'h4, 18'h2, 8'h0, 8'h00);
    run(3'h1, 18'h0, 8'h0, last);
    run(3'h0, 18'h2, 8'h0, mem[2]);
    run(3'h3, 18'h0, 8'h0, 8'hFF);
    foreach (mem[i]) mem[i] = 8'hFF;
    run(3'h0, 18'h7, 8'h0, 8'hFF);
    gate <= 1'b1;
    // programs only clear bits, so data stays inside the erased cell
    repeat (4) begin
      ad = 18'($urandom);
      d = 8'($urandom) & mem[ad[3:0]];
      mem[ad[3:0]] &= d;
      run(3'h2, ad, d, (d == 8'hFF) ? last : mem[ad[3:0]]);
      run(3'h1, 18'h0, 8'h0, last);
      run(3'h0, ad, 8'h0, mem[ad[3:0]]);
    end
    gate <= 1'b0;
    run(3'h2, 18'h5, 8'hFF, last);
    run(3'h0, 18'h5, 8'h0, mem[5]);
    run(3'h5, 18'h0, 8'h0, last);
    run(3'h0, 18'h9, 8'h0, mem[9]);
    repeat (4) @(posedge clk);
    conclude;
  end
endmodule : tb
